/* File: hw/mipwm_pkg.sv */
// constants and types for the interleaved multiphase pwm timing block
// Functional notes
// - With neither phase-3 nor phase-4 pin tied high, four phases run by default.
// - Each switching cycle starts when the internal cycle clock forces phase 1 low.
// - In four-phase mode phases 2, 3 and 4 terminate at 1/4 cycle steps after phase 1.
// - A tied-high phase-3 pin selects two phases, phase 2 terminating 1/2 cycle later.
// - A tied-high phase-4 pin with the phase-3 pin low selects three phases spaced in 1/3 cycle steps.
// - Every phase output that falls at its termination stays low for at least 1/3 of a cycle.
// - After the forced off time a phase rises when its modified level crosses its ramp.
// - The modified level is the compensation level minus the phase balance correction.
// - A high phase stays high until its own termination event at its next cycle start.
// - Sense logic exists per phase and channels beyond the detected count stay idle.
// - A channel current is captured only after it has settled following the fall.
// - Held samples feed current balance, the cycle average and overcurrent.
// - The sample window opens at the fall, lasts 1/3 cycle, and the value holds a cycle.
// - The cycle average is the sum of active samples divided by the active count.
package mipwm_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SW_PERIOD_NS = 1200;
    localparam int CYC_INT = SW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PHASES = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CYC_CNT = CNT_W'(CYC_INT);
    localparam logic [CNT_W-1:0] CYC_LAST = CNT_W'(CYC_INT - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] OFS_QTR = CNT_W'(CYC_INT / 4);
    localparam logic [CNT_W-1:0] OFS_HALF = CNT_W'(CYC_INT / 2);
    localparam logic [CNT_W-1:0] OFS_TQTR = CNT_W'((3 * CYC_INT) / 4);
    localparam logic [CNT_W-1:0] OFS_THIRD = CNT_W'(CYC_INT / 3);
    localparam logic [CNT_W-1:0] OFS_TTHIRD = CNT_W'((2 * CYC_INT) / 3);
    // least times round up to whole cycles
    localparam logic [CNT_W-1:0] OFF_MIN = CNT_W'((CYC_INT + 2) / 3);
    localparam logic [CNT_W-1:0] SAMP_CYC = CNT_W'((CYC_INT + 2) / 3);
    localparam logic [CNT_W-1:0] WIN_LAST = 8'h01;
    localparam logic [DATA_W-1:0] OC_LIMIT = 8'hc8;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] DATA_MAX = 8'hff;

    typedef logic [PHASES-1:0][DATA_W-1:0] mipwm_sense_t;

    typedef enum logic [1:0] {
        MIPWM_N4 = 2'b00,
        MIPWM_N2 = 2'b01,
        MIPWM_N3 = 2'b10
    } mipwm_mode_t;

    typedef enum logic {
        MIPWM_DETECT = 1'b0,
        MIPWM_RUN = 1'b1
    } mipwm_state_t;
endpackage : mipwm_pkg

/* File: hw/mipwm_ch_if.sv */
// per-channel link between the timing core and its sample-and-hold
`timescale 1ns/1ps
interface mipwm_ch_if;
    logic fall;
    logic active;
    logic [mipwm_pkg::DATA_W-1:0] sense_pos;
    logic [mipwm_pkg::DATA_W-1:0] sense_neg;
    logic [mipwm_pkg::DATA_W-1:0] sample;
    modport ctrl (output fall, output active, output sense_pos,
                  output sense_neg, input sample);
    modport chan (input fall, input active, input sense_pos,
                  input sense_neg, output sample);
endinterface : mipwm_ch_if

/* File: hw/mipwm_chan.sv */
// per-channel current sample-and-hold
`timescale 1ns/1ps
module mipwm_chan (
    input wire logic clk,
    input wire logic rst,
    mipwm_ch_if.chan ch
);
    import mipwm_pkg::*;

    logic [CNT_W-1:0] win_reg;
    logic [CNT_W-1:0] win_next;
    logic [DATA_W-1:0] sample_reg;
    logic [DATA_W-1:0] sample_next;
    logic cap;

    assign cap = (win_reg == WIN_LAST);
    assign ch.sample = sample_reg;

    always_comb begin
        win_next = win_reg;
        sample_next = sample_reg;
        if (!ch.active) begin
            win_next = CNT_ZERO;
            sample_next = DATA_ZERO;
        end else if (ch.fall) begin
            win_next = SAMP_CYC;
        end else if (win_reg != CNT_ZERO) begin
            win_next = win_reg - WIN_LAST;
        end
        // capture at window end so the sensed current has settled
        if (ch.active && cap) begin
            if (ch.sense_pos >= ch.sense_neg) begin
                sample_next = ch.sense_pos - ch.sense_neg;
            end else begin
                sample_next = DATA_ZERO;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            win_reg <= CNT_ZERO;
            sample_reg <= DATA_ZERO;
        end else begin
            win_reg <= win_next;
            sample_reg <= sample_next;
        end
    end

    // helper: cycles since the window opened, saturating
    logic [CNT_W-1:0] since_reg;
    always_ff @(posedge clk) begin
        if (rst || !ch.active) begin
            since_reg <= CNT_ZERO;
        end else if (ch.fall) begin
            since_reg <= WIN_LAST;
        end else if (since_reg != CNT_ZERO && since_reg != ~CNT_ZERO) begin
            since_reg <= since_reg + WIN_LAST;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    window_len_a: assert property (
        ch.active && since_reg != CNT_ZERO
            |-> cap == (since_reg == SAMP_CYC))
        else $error("sample window length wrong");
    settle_cap_a: assert property (
        !$stable(sample_reg) && ch.active && $past(ch.active)
            |-> $past(cap))
        else $error("sample changed before window end");
    hold_cycle_a: assert property (
        ch.active && cap ##1 ch.active [*8] |-> $stable(sample_reg))
        else $error("held sample not stable");
endmodule : mipwm_chan

/* File: hw/mipwm_top.sv */
// interleaved multiphase pwm timing core with per-phase sample-and-hold
`timescale 1ns/1ps
module mipwm_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic phase3_drive_in,
    input wire logic phase4_drive_in,
    input wire logic [mipwm_pkg::DATA_W-1:0] compensation_level,
    input wire mipwm_pkg::mipwm_sense_t current_sense_pos,
    input wire mipwm_pkg::mipwm_sense_t current_sense_neg,
    output logic phase1_drive,
    output logic phase2_drive,
    output logic phase3_drive,
    output logic phase3_drive_oe,
    output logic phase4_drive,
    output logic phase4_drive_oe,
    output logic [mipwm_pkg::DATA_W-1:0] cycle_average_current,
    output logic overcurrent,
    output mipwm_pkg::mipwm_mode_t phase_mode,
    output logic running
);
    import mipwm_pkg::*;

    mipwm_state_t state_reg;
    mipwm_state_t state_next;
    mipwm_mode_t mode_reg;
    mipwm_mode_t mode_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [PHASES-1:0] drive_reg;
    logic [PHASES-1:0] drive_next;
    logic [1:0] oe_reg;
    logic [1:0] oe_next;
    logic [DATA_W-1:0] avg_reg;
    logic [DATA_W-1:0] avg_next;
    logic oc_reg;
    logic oc_next;
    logic [PHASES-1:0] term;
    logic [PHASES-1:0] active;
    logic [PHASES-1:0][DATA_W-1:0] samp;

    function automatic logic [2:0] phase_count(input mipwm_mode_t m);
        case (m)
            MIPWM_N2: phase_count = 3'h2;
            MIPWM_N3: phase_count = 3'h3;
            default: phase_count = 3'h4;
        endcase
    endfunction : phase_count

    // termination offset of phase idx within the cycle
    function automatic logic [CNT_W-1:0] phase_offset(
        input mipwm_mode_t m,
        input int idx
    );
        phase_offset = CNT_ZERO;
        case (m)
            MIPWM_N2: begin
                if (idx == 1) phase_offset = OFS_HALF;
            end
            MIPWM_N3: begin
                if (idx == 1) phase_offset = OFS_THIRD;
                if (idx == 2) phase_offset = OFS_TTHIRD;
            end
            default: begin
                if (idx == 1) phase_offset = OFS_QTR;
                if (idx == 2) phase_offset = OFS_HALF;
                if (idx == 3) phase_offset = OFS_TQTR;
            end
        endcase
    endfunction : phase_offset

    // position of a phase's own sawtooth, zero at its termination
    function automatic logic [CNT_W-1:0] local_pos(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] ofs
    );
        if (cnt >= ofs) begin
            local_pos = cnt - ofs;
        end else begin
            local_pos = CNT_W'({1'b0, cnt} + {1'b0, CYC_CNT} - {1'b0, ofs});
        end
    endfunction : local_pos

    // compensation minus balance error, clamped to the data range
    function automatic logic [DATA_W-1:0] mod_level(
        input logic [DATA_W-1:0] comp,
        input logic [DATA_W-1:0] s,
        input logic [DATA_W-1:0] avg
    );
        logic signed [DATA_W+1:0] v;
        v = $signed({2'b00, comp}) - ($signed({2'b00, s})
            - $signed({2'b00, avg}));
        if (v < 0) begin
            mod_level = DATA_ZERO;
        end else if (v > $signed({2'b00, DATA_MAX})) begin
            mod_level = DATA_MAX;
        end else begin
            mod_level = v[DATA_W-1:0];
        end
    endfunction : mod_level

    genvar g;
    generate
        for (g = 0; g < PHASES; g++) begin : g_ch
            mipwm_ch_if ch ();
            assign ch.fall = term[g];
            assign ch.active = active[g];
            assign ch.sense_pos = current_sense_pos[g];
            assign ch.sense_neg = current_sense_neg[g];
            assign samp[g] = ch.sample;
            mipwm_chan u_chan (
                .clk(clk),
                .rst(rst),
                .ch(ch)
            );
        end
    endgenerate

    // mode detection and run control
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        case (state_reg)
            MIPWM_DETECT: begin
                // pins 3 and 4 are not driven here, so their ties read back
                if (enable) begin
                    state_next = MIPWM_RUN;
                    if (phase3_drive_in) begin
                        mode_next = MIPWM_N2;
                    end else if (phase4_drive_in) begin
                        mode_next = MIPWM_N3;
                    end else begin
                        mode_next = MIPWM_N4;
                    end
                end
            end
            default: begin
                if (!enable) state_next = MIPWM_DETECT;
            end
        endcase
    end

    // cycle clock and per-phase edges
    always_comb begin
        logic [CNT_W-1:0] pos;
        logic [DATA_W-1:0] lvl;
        logic run;
        pos = CNT_ZERO;
        lvl = DATA_ZERO;
        run = (state_reg == MIPWM_RUN) && enable;
        cnt_next = CNT_ZERO;
        if (run) begin
            cnt_next = (cnt_reg == CYC_LAST) ? CNT_ZERO : cnt_reg + WIN_LAST;
        end
        for (int i = 0; i < PHASES; i++) begin
            active[i] = run && (3'(i) < phase_count(mode_reg));
            pos = local_pos(cnt_reg, phase_offset(mode_reg, i));
            lvl = mod_level(compensation_level, samp[i], avg_reg);
            term[i] = active[i] && (pos == CNT_ZERO);
            drive_next[i] = drive_reg[i];
            if (!active[i] || term[i]) begin
                drive_next[i] = 1'b0;
            end else if (!drive_reg[i] && pos >= OFF_MIN
                && ({1'b0, pos} + {1'b0, lvl}) >= {1'b0, CYC_CNT}) begin
                drive_next[i] = 1'b1;
            end
        end
        oe_next = active[3:2];
    end

    // balance average and overcurrent from held samples
    always_comb begin
        logic [DATA_W+1:0] sum;
        sum = '0;
        oc_next = 1'b0;
        for (int i = 0; i < PHASES; i++) begin
            if (3'(i) < phase_count(mode_reg)) begin
                sum = sum + {2'b00, samp[i]};
                if (samp[i] > OC_LIMIT) oc_next = 1'b1;
            end
        end
        case (mode_reg)
            MIPWM_N2: avg_next = DATA_W'(sum / 2);
            MIPWM_N3: avg_next = DATA_W'(sum / 3);
            default: avg_next = DATA_W'(sum / 4);
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= MIPWM_DETECT;
            mode_reg <= MIPWM_N4;
            cnt_reg <= CNT_ZERO;
            drive_reg <= '0;
            oe_reg <= 2'b00;
            avg_reg <= DATA_ZERO;
            oc_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            cnt_reg <= cnt_next;
            drive_reg <= drive_next;
            oe_reg <= oe_next;
            avg_reg <= avg_next;
            oc_reg <= oc_next;
        end
    end

    assign phase1_drive = drive_reg[0];
    assign phase2_drive = drive_reg[1];
    assign phase3_drive = drive_reg[2];
    assign phase4_drive = drive_reg[3];
    assign phase3_drive_oe = oe_reg[0];
    assign phase4_drive_oe = oe_reg[1];
    assign cycle_average_current = avg_reg;
    assign overcurrent = oc_reg;
    assign phase_mode = mode_reg;
    assign running = state_reg;

    // helper: low cycles of phase 1 since it last fell
    logic [CNT_W-1:0] low_cnt_reg;
    always_ff @(posedge clk) begin
        if (rst || drive_reg[0]) begin
            low_cnt_reg <= CNT_ZERO;
        end else if (low_cnt_reg != DATA_MAX) begin
            low_cnt_reg <= low_cnt_reg + WIN_LAST;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    default_four_a: assert property (
        state_reg == MIPWM_DETECT && enable && !phase3_drive_in
            && !phase4_drive_in |=> phase_mode == MIPWM_N4 && running)
        else $error("default mode not four phases");
    two_phase_a: assert property (
        state_reg == MIPWM_DETECT && enable && phase3_drive_in
            |=> phase_mode == MIPWM_N2 && !phase3_drive_oe [*4])
        else $error("two phase tie not honoured");
    three_phase_a: assert property (
        state_reg == MIPWM_DETECT && enable && !phase3_drive_in
            && phase4_drive_in |=> phase_mode == MIPWM_N3)
        else $error("three phase tie not honoured");
    mode_fixed_a: assert property (
        running && $past(running) |-> $stable(phase_mode))
        else $error("phase count changed while running");
    cycle_start_a: assert property (
        running && enable && cnt_reg == CNT_ZERO |=> !phase1_drive)
        else $error("phase 1 not low at cycle start");
    quarter_step_a: assert property (
        running && enable && phase_mode == MIPWM_N4 && cnt_reg == OFS_QTR
            |=> !phase2_drive)
        else $error("phase 2 not terminated at quarter cycle");
    forced_off_a: assert property (
        $rose(phase1_drive) |-> low_cnt_reg >= OFF_MIN)
        else $error("phase 1 rose inside forced off time");
    hold_high_a: assert property (
        phase1_drive && enable && cnt_reg != CNT_ZERO |=> phase1_drive)
        else $error("phase 1 fell without termination");
    idle_chan_a: assert property (
        running && phase_mode == MIPWM_N2 |=> !phase3_drive && !phase4_drive)
        else $error("inactive channel driven");

    four_run_c: cover property (phase_mode == MIPWM_N4 && $rose(phase4_drive));
    three_run_c: cover property (phase_mode == MIPWM_N3 && $rose(phase3_drive));
    two_run_c: cover property (phase_mode == MIPWM_N2 && $rose(phase2_drive));
    overcurrent_c: cover property ($rose(overcurrent));
endmodule : mipwm_top

/* File: tb/mipwm_drv_model.sv */
// behavioural model of the per-phase external mosfet drivers
`timescale 1ns/1ps
module mipwm_drv_model (
    input wire logic [3:0] pwm_in,
    input wire mipwm_pkg::mipwm_sense_t inductor_current,
    output logic [3:0] upper_on,
    output logic [3:0] lower_on,
    output mipwm_pkg::mipwm_sense_t sense_pos,
    output mipwm_pkg::mipwm_sense_t sense_neg
);
    import mipwm_pkg::*;
    always_comb begin
        for (int i = 0; i < PHASES; i++) begin
            upper_on[i] = pwm_in[i];
            lower_on[i] = ~pwm_in[i];
            // reading is only valid while the lower switch conducts; the
            // swinging phase node shows as garbage, so early samples fail
            sense_pos[i] = lower_on[i] ? inductor_current[i]
                                       : ~inductor_current[i];
            sense_neg[i] = DATA_ZERO;
        end
    end
endmodule : mipwm_drv_model

/* File: tb/testbench.sv */
// self-checking bench for the interleaved multiphase pwm timing block
`timescale 1ns/1ps
module testbench;
    import mipwm_pkg::*;
    localparam int CYC = 240;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic enable = 1'b0;
    logic tie3 = 1'b0;
    logic tie4 = 1'b0;
    logic [DATA_W-1:0] comp = 8'hff;
    mipwm_sense_t cur = '0;
    mipwm_sense_t s_pos;
    mipwm_sense_t s_neg;
    wire logic [3:0] drv;
    logic [3:0] drv_q = 4'h0;
    logic p3_oe, p4_oe, oc, run;
    logic [DATA_W-1:0] avg;
    mipwm_mode_t mode;
    int cyc = 0;
    int fall_t[4];
    int low_n[4];
    int t0;
    int miscompares = 0;
    int checks_done = 0;
    // undriven pins follow their tie-off
    wire logic p3_pin = p3_oe ? drv[2] : tie3;
    wire logic p4_pin = p4_oe ? drv[3] : tie4;

    always #2.5 clk = ~clk;

    mipwm_top dut (.clk(clk), .rst(rst), .enable(enable),
        .phase3_drive_in(p3_pin), .phase4_drive_in(p4_pin),
        .compensation_level(comp), .current_sense_pos(s_pos),
        .current_sense_neg(s_neg), .phase1_drive(drv[0]),
        .phase2_drive(drv[1]), .phase3_drive(drv[2]),
        .phase3_drive_oe(p3_oe), .phase4_drive(drv[3]),
        .phase4_drive_oe(p4_oe), .cycle_average_current(avg),
        .overcurrent(oc), .phase_mode(mode), .running(run));

    mipwm_drv_model drivers (.pwm_in(drv), .inductor_current(cur),
        .upper_on(), .lower_on(), .sense_pos(s_pos), .sense_neg(s_neg));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        drv_q <= drv;
        for (int i = 0; i < 4; i++) begin
            if (drv_q[i] && !drv[i]) fall_t[i] <= cyc;
            if (!drv_q[i] && drv[i]) low_n[i] <= cyc - fall_t[i];
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk

    function automatic int gap(input int i);
        return ((fall_t[i] - fall_t[0]) % CYC + CYC) % CYC;
    endfunction : gap

    task automatic start(input logic t3, input logic t4, input int n);
        @(negedge clk);
        enable = 1'b0;
        repeat (2) @(negedge clk);
        tie3 = t3;
        tie4 = t4;
        enable = 1'b1;
        repeat (n * CYC) @(negedge clk);
    endtask : start

    task automatic test_four();
        chk("drives in reset", 0, drv);
        chk("running in reset", 0, run);
        chk("average in reset", 0, avg);
        @(negedge clk);
        rst = 1'b0;
        start(1'b0, 1'b0, 4);
        chk("default mode", MIPWM_N4, mode);
        chk("running", 1, run);
        chk("pin enables", 3, {p4_oe, p3_oe});
        chk("phase2 offset", 60, gap(1));
        chk("phase3 offset", 120, gap(2));
        chk("phase4 offset", 180, gap(3));
        for (int i = 0; i < 4; i++) chk("forced off", 80, low_n[i]);
        t0 = fall_t[0];
        repeat (CYC) @(negedge clk);
        chk("cycle length", CYC, fall_t[0] - t0);
        $display("test four done");
    endtask : test_four

    task automatic test_two();
        start(1'b1, 1'b0, 3);
        chk("two mode", MIPWM_N2, mode);
        chk("phase2 offset", 120, gap(1));
        chk("idle phases", 0, drv[3:2]);
        chk("idle oe", 0, {p3_oe, p4_oe});
        start(1'b1, 1'b1, 1);
        chk("both ties", MIPWM_N2, mode);
        $display("test two done");
    endtask : test_two

    task automatic test_three();
        start(1'b0, 1'b1, 3);
        chk("three mode", MIPWM_N3, mode);
        chk("phase2 offset", 80, gap(1));
        chk("phase3 offset", 160, gap(2));
        chk("idle phase4", 0, {drv[3], p4_oe});
        chk("forced off", 80, low_n[2]);
        $display("test three done");
    endtask : test_three

    task automatic test_balance();
        comp = 8'h64;
        cur = {8'h28, 8'h28, 8'h28, 8'h50};
        start(1'b0, 1'b0, 4);
        chk("average", 50, avg);
        chk("phase1 low", 170, low_n[0]);
        chk("phase2 low", 130, low_n[1]);
        comp = 8'h00;
        repeat (3 * CYC) @(negedge clk);
        chk("clamped low", 230, low_n[1]);
        for (int k = 0; k < 8; k++) begin
            repeat (CYC / 8) @(negedge clk);
            chk("no crossing", 0, drv[0]);
        end
        $display("test balance done");
    endtask : test_balance

    task automatic test_current();
        comp = 8'hff;
        cur = {8'hfa, 8'h5a, 8'h3c, 8'h1e};
        start(1'b0, 1'b1, 4);
        chk("average", 60, avg);
        chk("overcurrent", 0, oc);
        @(negedge clk);
        cur[2] = 8'hd2;
        repeat (2 * CYC) @(negedge clk);
        chk("average", 100, avg);
        chk("overcurrent", 1, oc);
        $display("test current done");
    endtask : test_current

    task automatic test_lock();
        start(1'b0, 1'b0, 1);
        tie3 = 1'b1;
        tie4 = 1'b1;
        repeat (CYC) @(negedge clk);
        chk("mode locked", MIPWM_N4, mode);
        enable = 1'b0;
        repeat (2) @(negedge clk);
        chk("stopped", 0, run);
        chk("stopped drives", 0, drv);
        $display("test lock done");
    endtask : test_lock

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // whole run is about 28 switching cycles; allow 400, over fourteen times that
    initial begin
        #(400 * CYC * 5);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (4) @(negedge clk);
        test_four();
        test_two();
        test_three();
        test_balance();
        test_current();
        test_lock();
        wrap_up();
    end
endmodule : testbench
